// ==== tcc_pkg.sv ====
package tcc_pkg;
   // Register map, one aligned word each, data in bits [7:0]
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_IIR = 8'h04;
   localparam logic [7:0] OFS_IER = 8'h08;
   localparam logic [7:0] OFS_DR_L = 8'h0C;
   localparam logic [7:0] OFS_DR_H = 8'h10;
   localparam logic [7:0] OFS_CAP_CTL = 8'h14;
   localparam logic [7:0] OFS_CAPA_L = 8'h18;
   localparam logic [7:0] OFS_CAP_STEP = 8'h08;
   localparam logic [7:0] OFS_OC_CTL1 = 8'h28;
   localparam logic [7:0] OFS_OC_CTL2 = 8'h2C;
   localparam logic [7:0] OFS_OC0_L = 8'h30;
   localparam logic [7:0] OFS_OC_STEP = 8'h08;
   localparam logic [7:0] OFS_HIGH = 8'h04;
   // Control field positions
   localparam int CTL_EN = 0;
   localparam int CTL_RLD = 1;
   localparam int CTL_CONT = 2;
   localparam int CTL_DIV = 3;
   localparam int CTL_SEL = 5;
   // Cause and enable bit positions
   localparam int IIR_EOC = 0;
   localparam int IIR_ICA = 1;
   localparam int IIR_OC = 3;
   localparam int IIR_W = 7;
   // Compare control 1 positions
   localparam int OC1_EN = 0;
   localparam int OC1_MAST = 1;
   localparam int OC1_INIT = 4;
   // Clock source codes
   localparam logic [1:0] SEL_SYS = 2'h0;
   localparam logic [1:0] SEL_RTC = 2'h1;
   localparam logic [1:0] SEL_FALL = 2'h2;
   localparam logic [1:0] SEL_RISE = 2'h3;
   // Compare actions
   localparam logic [1:0] ACT_FORCE = 2'h0;
   localparam logic [1:0] ACT_CLEAR = 2'h1;
   localparam logic [1:0] ACT_SET = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Prescaler masks for divide by 4, 16, 64, 256
   localparam logic [7:0] PRE_MASK_4 = 8'h03;
   localparam logic [7:0] PRE_MASK_16 = 8'h0F;
   localparam logic [7:0] PRE_MASK_64 = 8'h3F;
   localparam logic [7:0] PRE_MASK_256 = 8'hFF;
   // Reset values and bus answers
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] CNT_LAST = 16'h0001;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] sel;
      logic [1:0] div;
      logic cont;
      logic en;
   } tcc_ctl_t;

   typedef enum logic [0:0] {
      W_IDLE = 1'b0,
      W_RESP = 1'b1
   } tcc_wstate_t;

   // Capture edge field: bit 0 rising, bit 1 falling, both set for both
   function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                     input logic fall);
      return (mode[0] & rise) | (mode[1] & fall);
   endfunction : edge_hit
endpackage : tcc_pkg

// ==== tcc_edge_sample.sv ====
module tcc_edge_sample #(
   parameter int N = 4
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [N-1:0] i_pin,
   output logic [N-1:0] o_rise,
   output logic [N-1:0] o_fall
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] last_q;

   // Two-stage sampler then a history stage; edges seen after the second edge
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
         last_q <= '0;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edge pulses only look at the settled stages
   for (genvar g = 0; g < N; g++) begin : g_edge
      assign o_rise[g] = sync_q[g] & ~last_q[g];
      assign o_fall[g] = ~sync_q[g] & last_q[g];
   end
endmodule : tcc_edge_sample

// ==== tcc_timer.sv ====
// How it works
// - Modulation mode enabled blocks capture and compare; both may run together.
// - Reading the cause register clears it; later events stay separate.
// - Pin source bypasses prescaler; counter decrements once per chosen edge.
// - Pin sampled; counter updates on third clock edge after pin edge.
// - Event mode reload, end-of-count and interrupts match basic timer.
// - Real-time clock source samples internal clock like event mode.
// - Capture edge latches 16-bit count into that channel's pair.
// - Low byte read blocks that pin's captures until high byte read.
// - Capture value registers read-only; writes change nothing.
// - Capture sets channel flag; interrupt only when its enable set.
// - Four compare outputs, each with its own 16-bit compare value.
// - Match applies selected action: set, clear or toggle.
// - Compare outputs start at 0 unless initialised to 1.
// - Action 0 forces initial level; level kept until next action.
// - Master mode: outputs 1 to 3 follow output 0 configuration.
// - Match sets output's compare flag; interrupt only when enabled.
// - Count readback read-only, reload write-only, same addresses.
// - Capabilities fixed per timer by parameters.
// - Source codes: 01 real-time clock, 10 falling pin, 11 rising pin.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
module tcc_timer
   import tcc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter bit HAS_EVENT = 1'b1,
   parameter bit HAS_CAPTURE = 1'b1,
   parameter bit HAS_COMPARE = 1'b1
) (
   input wire logic I_CLOCK,
   input wire logic I_RESET_N,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [ADDR_W-1:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [ADDR_W-1:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   input wire logic I_EVENT_COUNT_PIN,
   input wire logic I_RTC_CLOCK,
   input wire logic [1:0] I_CAPTURE_PIN,
   input wire logic I_MULTI_MODULATION_ENABLE,
   output logic [3:0] O_COMPARE_OUTPUT_N,
   output logic O_TIMER_IRQ
);
   logic rst_meta_q, rst_n;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [7:0] w_data_q, rd_byte, pre_q, pre_mask, hold_q;
   logic [7:0] ier_q, cap_ctl_q, oc1_q, oc2_q;
   logic w_strb_q, wr_go, rd_go, tick, pre_tick, eoc_ev, force_rld, cnt_new_q;
   tcc_wstate_t wstate_q;
   tcc_ctl_t ctl_q;
   logic [15:0] cnt_q, rld_q;
   logic [15:0] cap_q [2];
   logic [15:0] oc_val_q [4];
   logic [1:0] lock_q, cap_ev;
   logic [3:0] rise, fall, match, out_q;
   logic [IIR_W-1:0] iir_q, iir_d, ev;
   logic cap_on, oc_on;

   // Reset released through two flops, asserted at once
   always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Unaligned or unknown offsets answer with an error
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] o;
      o = 8'(a);
      return (a[1:0] == 2'b00) && (o <= OFS_OC0_L + 8'(3) * OFS_OC_STEP + OFS_HIGH)
             && (ADDR_W <= 8 || (a >> 8) == '0);
   endfunction : mapped

   function automatic logic wr_hit(input logic [7:0] ofs);
      return wr_go && w_strb_q && (aw_addr_q == ADDR_W'(ofs));
   endfunction : wr_hit

   function automatic logic rd_hit(input logic [7:0] ofs);
      return rd_go && (I_ARADDR == ADDR_W'(ofs));
   endfunction : rd_hit

   // Pin sampling: {rtc, capture second, capture first, event}
   tcc_edge_sample #(.N(4)) u_sample (
      .i_clock(I_CLOCK),
      .i_reset_n(rst_n),
      .i_pin({I_RTC_CLOCK, I_CAPTURE_PIN, I_EVENT_COUNT_PIN}),
      .o_rise(rise),
      .o_fall(fall)
   );

   // Write channel: address and data taken in any order, then one write
   assign wr_go = (wstate_q == W_IDLE) && !awready_q && !wready_q;
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_addr_q <= '0;
         w_data_q <= RST_BYTE;
         w_strb_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         wstate_q <= W_IDLE;
      end else begin
         if (I_AWVALID && awready_q) begin
            aw_addr_q <= I_AWADDR;
            awready_q <= 1'b0;
         end
         if (I_WVALID && wready_q) begin
            w_data_q <= I_WDATA[7:0];
            w_strb_q <= I_WSTRB[0];
            wready_q <= 1'b0;
         end
         case (wstate_q)
            W_IDLE: if (wr_go) begin
               bvalid_q <= 1'b1;
               bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
               wstate_q <= W_RESP;
            end
            W_RESP: if (I_BREADY) begin
               bvalid_q <= 1'b0;
               awready_q <= 1'b1;
               wready_q <= 1'b1;
               wstate_q <= W_IDLE;
            end
            default: wstate_q <= W_IDLE;
         endcase
      end
   end

   // Read mux; count readback shares the reload offsets
   always_comb begin
      rd_byte = RST_BYTE;
      case (I_ARADDR)
         ADDR_W'(OFS_CTL): rd_byte = {1'b0, ctl_q.sel, ctl_q.div, ctl_q.cont, 1'b0, ctl_q.en};
         ADDR_W'(OFS_IIR): rd_byte = {1'b0, iir_q};
         ADDR_W'(OFS_IER): rd_byte = ier_q;
         ADDR_W'(OFS_DR_L): rd_byte = cnt_q[7:0];
         ADDR_W'(OFS_DR_H): rd_byte = hold_q;
         ADDR_W'(OFS_CAP_CTL): rd_byte = cap_ctl_q;
         ADDR_W'(OFS_OC_CTL1): rd_byte = oc1_q;
         ADDR_W'(OFS_OC_CTL2): rd_byte = oc2_q;
         default: begin
            for (int c = 0; c < 2; c++) begin
               if (I_ARADDR == ADDR_W'(OFS_CAPA_L + 8'(c) * OFS_CAP_STEP)) begin
                  rd_byte = cap_q[c][7:0];
               end
               if (I_ARADDR == ADDR_W'(OFS_CAPA_L + 8'(c) * OFS_CAP_STEP + OFS_HIGH)) begin
                  rd_byte = cap_q[c][15:8];
               end
            end
            for (int i = 0; i < 4; i++) begin
               if (I_ARADDR == ADDR_W'(OFS_OC0_L + 8'(i) * OFS_OC_STEP)) begin
                  rd_byte = oc_val_q[i][7:0];
               end
               if (I_ARADDR == ADDR_W'(OFS_OC0_L + 8'(i) * OFS_OC_STEP + OFS_HIGH)) begin
                  rd_byte = oc_val_q[i][15:8];
               end
            end
         end
      endcase
   end

   // Read channel: one cycle to answer, side effects on the taking edge
   assign rd_go = I_ARVALID && arready_q;
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (rd_go) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_byte};
         rresp_q <= mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && I_RREADY) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Software-written configuration; single pass end drops the enable
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= '0;
         ier_q <= RST_BYTE;
         cap_ctl_q <= RST_BYTE;
         oc1_q <= RST_BYTE;
         oc2_q <= RST_BYTE;
         rld_q <= RST_COUNT;
      end else begin
         if (eoc_ev && !ctl_q.cont) begin
            ctl_q.en <= 1'b0;
         end
         if (wr_hit(OFS_CTL)) begin
            ctl_q <= tcc_ctl_t'({w_data_q[CTL_SEL+:2], w_data_q[CTL_DIV+:2],
                                 w_data_q[CTL_CONT], w_data_q[CTL_EN]});
         end
         if (wr_hit(OFS_IER)) ier_q <= w_data_q;
         if (wr_hit(OFS_CAP_CTL)) cap_ctl_q <= w_data_q;
         if (wr_hit(OFS_OC_CTL1)) oc1_q <= w_data_q;
         if (wr_hit(OFS_OC_CTL2)) oc2_q <= w_data_q;
         if (wr_hit(OFS_DR_L)) rld_q[7:0] <= w_data_q;
         if (wr_hit(OFS_DR_H)) rld_q[15:8] <= w_data_q;
      end
   end

   // Compare values, one byte per write
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) oc_val_q[i] <= RST_COUNT;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wr_hit(OFS_OC0_L + 8'(i) * OFS_OC_STEP)) oc_val_q[i][7:0] <= w_data_q;
            if (wr_hit(OFS_OC0_L + 8'(i) * OFS_OC_STEP + OFS_HIGH)) begin
               oc_val_q[i][15:8] <= w_data_q;
            end
         end
      end
   end

   // Prescaler free-runs so a divider change takes effect within one period
   always_comb begin
      case (ctl_q.div)
         2'h0: pre_mask = PRE_MASK_4;
         2'h1: pre_mask = PRE_MASK_16;
         2'h2: pre_mask = PRE_MASK_64;
         default: pre_mask = PRE_MASK_256;
      endcase
      pre_tick = (pre_q & pre_mask) == pre_mask;
      case (ctl_q.sel)
         SEL_SYS: tick = pre_tick;
         SEL_RTC: tick = rise[3];
         SEL_FALL: tick = HAS_EVENT && fall[0];
         default: tick = HAS_EVENT && rise[0];
      endcase
      force_rld = wr_hit(OFS_CTL) && w_data_q[CTL_RLD];
      eoc_ev = ctl_q.en && tick && !force_rld && cnt_q == CNT_LAST;
   end

   // Down-counter; reload value 0 runs the full 65536 steps
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= RST_BYTE;
         cnt_q <= RST_COUNT;
         cnt_new_q <= 1'b0;
         hold_q <= RST_BYTE;
      end else begin
         pre_q <= pre_q + 8'h01;
         cnt_new_q <= force_rld || (ctl_q.en && tick);
         if (force_rld) begin
            cnt_q <= rld_q;
         end else if (ctl_q.en && tick) begin
            if (cnt_q == CNT_LAST) begin
               cnt_q <= ctl_q.cont ? rld_q : RST_COUNT;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
         if (rd_hit(OFS_DR_L)) hold_q <= cnt_q[15:8];
      end
   end

   // Capture: latch count, lock the pair between low and high byte reads
   assign cap_on = HAS_CAPTURE && !I_MULTI_MODULATION_ENABLE;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         // A capture on the low byte's own read edge would tear the pair
         cap_ev[c] = cap_on && !lock_q[c] && !rd_hit(OFS_CAPA_L + 8'(c) * OFS_CAP_STEP)
                     && edge_hit(cap_ctl_q[2*c+:2], rise[c+1], fall[c+1]);
      end
   end
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 2; c++) cap_q[c] <= RST_COUNT;
         lock_q <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (cap_ev[c]) cap_q[c] <= cnt_q;
            if (rd_hit(OFS_CAPA_L + 8'(c) * OFS_CAP_STEP)) begin
               lock_q[c] <= 1'b1;
            end else if (rd_hit(OFS_CAPA_L + 8'(c) * OFS_CAP_STEP + OFS_HIGH)) begin
               lock_q[c] <= 1'b0;
            end
         end
      end
   end

   // Compare channels; master mode routes output 0 settings to all
   assign oc_on = HAS_COMPARE && oc1_q[OC1_EN] && !I_MULTI_MODULATION_ENABLE;
   for (genvar g = 0; g < 4; g++) begin : g_oc
      logic [1:0] mode;
      logic init;
      logic [15:0] val;
      assign mode = oc1_q[OC1_MAST] ? oc2_q[1:0] : oc2_q[2*g+:2];
      assign init = oc1_q[OC1_MAST] ? oc1_q[OC1_INIT] : oc1_q[OC1_INIT+g];
      assign val = oc1_q[OC1_MAST] ? oc_val_q[0] : oc_val_q[g];
      // Only on the cycle after the count moves, so a held count acts once
      assign match[g] = oc_on && cnt_new_q && cnt_q == val && mode != ACT_FORCE;
      always_ff @(posedge I_CLOCK or negedge rst_n) begin
         if (!rst_n) begin
            out_q[g] <= 1'b0;
         end else if (mode == ACT_FORCE) begin
            out_q[g] <= init;
         end else if (match[g]) begin
            case (mode)
               ACT_CLEAR: out_q[g] <= 1'b0;
               ACT_SET: out_q[g] <= 1'b1;
               default: out_q[g] <= ~out_q[g];
            endcase
         end
      end
   end

   // Cause flags: a new event wins over the clearing read
   always_comb begin
      ev = {match, cap_ev, eoc_ev};
      iir_d = (rd_hit(OFS_IIR) ? '0 : iir_q) | ev;
   end
   always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         iir_q <= '0;
         irq_q <= 1'b0;
      end else begin
         iir_q <= iir_d;
         irq_q <= |(iir_d & ier_q[IIR_W-1:0]);
      end
   end

   assign O_AWREADY = awready_q;
   assign O_WREADY = wready_q;
   assign O_BVALID = bvalid_q;
   assign O_BRESP = bresp_q;
   assign O_ARREADY = arready_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA = rdata_q;
   assign O_RRESP = rresp_q;
   assign O_COMPARE_OUTPUT_N = out_q;
   assign O_TIMER_IRQ = irq_q;

   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!rst_n);

   iir_clear_a: assert property (rd_hit(OFS_IIR) && ev == '0 |=> iir_q == '0)
      else $error("cause register not cleared by read");
   pwm_block_a: assert property (I_MULTI_MODULATION_ENABLE |-> ev[IIR_W-1:1] == '0)
      else $error("capture or compare active in modulation mode");
   event_delay_a: assert property (ctl_q.en && ctl_q.sel == SEL_RISE && cnt_q > 16'h0002
      && $rose(I_EVENT_COUNT_PIN) && !force_rld ##1 !force_rld ##1 !force_rld
      |=> cnt_q == $past(cnt_q, 3) - 16'h0001)
      else $error("event edge not counted on third clock edge");
   cap_latch_a: assert property (cap_ev[0] |=> cap_q[0] == $past(cnt_q))
      else $error("capture did not latch the count");
   cap_lock_a: assert property (lock_q[1] |-> !cap_ev[1] ##1 $stable(cap_q[1]))
      else $error("capture overwrote a locked pair");
   cap_ro_a: assert property (wr_go && !cap_ev[0] |=> $stable(cap_q[0]))
      else $error("write altered a capture value");
   cap_flag_a: assert property (cap_ev[0] |=> iir_q[IIR_ICA] && (irq_q || !$past(ier_q[IIR_ICA])))
      else $error("capture flag or request wrong");
   oc_force_a: assert property (!oc1_q[OC1_MAST] && oc2_q[1:0] == ACT_FORCE
      |=> out_q[0] == $past(oc1_q[OC1_INIT]))
      else $error("forced level not driven");
   oc_set_a: assert property (match[2] && g_oc[2].mode == ACT_SET |=> out_q[2])
      else $error("set action not applied");
   oc_once_a: assert property (match[0] && ctl_q.en == 1'b0 && !force_rld |=> !match[0])
      else $error("compare acted twice on a held count");
   oc_master_a: assert property (oc1_q[OC1_MAST] |-> match[3] == match[0])
      else $error("follower output not tracking output 0");
   oc_flag_a: assert property (match[1] |=> iir_q[IIR_OC+1])
      else $error("compare flag not set");
   eoc_reload_a: assert property (eoc_ev && ctl_q.cont |=> cnt_q == $past(rld_q))
      else $error("continuous reload missed");

   cap_seen_c: cover property (cap_ev[1] ##1 iir_q[IIR_ICA+1]);
   oc_toggle_c: cover property (match[0] && g_oc[0].mode == ACT_TOGGLE);
   eoc_seen_c: cover property (eoc_ev ##[1:4] rd_hit(OFS_IIR));
endmodule : tcc_timer

// ==== tcc_pins_model.sv ====
// Far-side pins: bit 0 event, bit 1 real-time clock, bit 2 capture A, bit 3 capture B
module tcc_pins_model (
   input wire logic i_clk,
   output logic [3:0] o_pins
);
   timeunit 1ns;
   timeprecision 100ps;

   // All pins idle low between pulses
   initial begin
      o_pins = 4'h0;
   end

   // Two clocks high, three low between repeats: stays well under half the clock rate
   task automatic pulse(input logic [3:0] m, input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_pins <= o_pins | m;
         repeat (2) @(posedge i_clk);
         o_pins <= o_pins & ~m;
         repeat (2) @(posedge i_clk);
      end
   endtask : pulse
endmodule : tcc_pins_model

// ==== tb_timer_capture_compare_modes.sv ====
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module tb_timer_capture_compare_modes import tcc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, mm = 1'b0;
   logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] w_d = 32'h0000_0000;
   logic awrdy, wrdy, bvld, arrdy, rvld, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] oc, pins;
   logic [33:0] ex;
   logic [33:0] expq[$];
   logic [15:0] rl, c;
   int n_fail = 0, checks = 0, seed = 39239, cyc = 0;

   always #12.5 clk = ~clk;

   tcc_timer u_dut (.I_CLOCK(clk), .I_RESET_N(rst_n),
      .I_AWVALID(aw_v), .O_AWREADY(awrdy), .I_AWADDR(aw_a), .I_WVALID(w_v),
      .O_WREADY(wrdy), .I_WDATA(w_d), .I_WSTRB(4'hF), .O_BVALID(bvld),
      .I_BREADY(b_r), .O_BRESP(bresp), .I_ARVALID(ar_v), .O_ARREADY(arrdy),
      .I_ARADDR(ar_a), .O_RVALID(rvld), .I_RREADY(r_r), .O_RDATA(rdata),
      .O_RRESP(rresp), .I_EVENT_COUNT_PIN(pins[0]), .I_RTC_CLOCK(pins[1]),
      .I_CAPTURE_PIN(pins[3:2]), .I_MULTI_MODULATION_ENABLE(mm),
      .O_COMPARE_OUTPUT_N(oc), .O_TIMER_IRQ(irq));

   tcc_pins_model u_pm (.i_clk(clk), .o_pins(pins));

   task automatic conclude();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = RESP_OKAY);
      @(posedge clk);
      expq.push_back({r, 32'h0000_0000});
      aw_a <= a;
      w_d <= {24'($random(seed)), d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      do begin
         @(posedge clk);
         if (awrdy) aw_v <= 1'b0;
         if (wrdy) w_v <= 1'b0;
      end while (!bvld);
      b_r <= 1'b0;
   endtask : wr

   // Read: expectation queued first, the watcher compares the answer
   task automatic rd(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = RESP_OKAY);
      @(posedge clk);
      expq.push_back({r, 24'h00_0000, d});
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do begin
         @(posedge clk);
         if (arrdy) ar_v <= 1'b0;
      end while (!rvld);
      r_r <= 1'b0;
   endtask : rd

   // Low byte first so the pair reads coherently
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + OFS_HIGH, v[15:8]);
   endtask : wr16

   task automatic rd16(input logic [7:0] a, input logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + OFS_HIGH, v[15:8]);
   endtask : rd16

   // Watcher takes the oldest note at every read or write handshake
   always @(posedge clk) begin
      if (rvld && r_r) begin
         ex = expq.pop_front();
         `CHK({rresp, rdata}, ex)
      end
      if (bvld && b_r) begin
         ex = expq.pop_front();
         `CHK({bresp, 32'h0000_0000}, ex)
      end
   end

   // Hang guard, generous against roughly four hundred cycles of traffic
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         conclude();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(OFS_CTL, RST_BYTE);
      rd(OFS_IER, RST_BYTE);
      rd(8'h50, 8'h00, RESP_SLVERR);
      wr(8'h50, 8'h00, RESP_SLVERR);
      `CHK(oc, 4'h0)
      rl = 16'h0020 + 16'($random(seed) & 15);
      wr16(OFS_DR_L, rl);
      // Source codes 1 to 3: reload, three events, count must drop by three
      for (int s = 1; s < 4; s++) begin
         wr(OFS_CTL, {1'b0, 2'(s), 2'b00, 3'b111});
         u_pm.pulse(s == 1 ? 4'h2 : 4'h1, 3);
         repeat (4) @(posedge clk);
         rd16(OFS_DR_L, rl - 16'd3);
      end
      c = rl - 16'd3;
      wr(OFS_IER, 8'h06);
      wr(OFS_CAP_CTL, 8'h01);
      u_pm.pulse(4'h4, 1);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b1)
      rd16(OFS_CAPA_L, c);
      rd(OFS_IIR, 8'h02);
      rd(OFS_IIR, 8'h00);
      `CHK(irq, 1'b0)
      // Low byte read locks the channel; a capture meanwhile is lost
      rd(OFS_CAPA_L, c[7:0]);
      u_pm.pulse(4'h1, 1);
      u_pm.pulse(4'h4, 1);
      rd(OFS_CAPA_L + OFS_HIGH, c[15:8]);
      wr(OFS_CAPA_L, 8'hFF);
      rd16(OFS_CAPA_L, c);
      rd(OFS_IIR, 8'h00);
      c = c - 16'd1;
      wr(OFS_CAP_CTL, 8'h0C);
      u_pm.pulse(4'h8, 1);
      rd16(OFS_CAPA_L + OFS_CAP_STEP, c);
      rd(OFS_IIR, 8'h04);
      // Forced levels before compare is enabled
      wr(OFS_OC_CTL1, 8'h40);
      wr(OFS_OC_CTL2, 8'h00);
      `CHK(oc, 4'b0100)
      wr16(OFS_OC0_L, c - 16'd2);
      for (int i = 1; i < 4; i++) begin
         wr16(OFS_OC0_L + OFS_OC_STEP * 8'(i), i < 3 ? c - 16'd1 : c + 16'd5);
      end
      wr(OFS_OC_CTL2, 8'h1B);
      wr(OFS_IER, 8'h08);
      wr(OFS_OC_CTL1, 8'h41);
      `CHK(oc, 4'b0100)
      u_pm.pulse(4'h1, 2);
      repeat (8) @(posedge clk);
      `CHK(oc, 4'b0011)
      `CHK(irq, 1'b1)
      rd(OFS_IIR, 8'h38);
      c = c - 16'd2;
      // Modulation mode shuts capture out
      mm <= 1'b1;
      wr(OFS_CAP_CTL, 8'h0F);
      u_pm.pulse(4'hC, 1);
      rd(OFS_IIR, 8'h00);
      mm <= 1'b0;
      wr16(OFS_OC0_L, c - 16'd1);
      wr(OFS_OC_CTL1, 8'h03);
      u_pm.pulse(4'h1, 1);
      repeat (8) @(posedge clk);
      `CHK(oc, 4'b1100)
      rd(OFS_IIR, 8'h78);
      // Prescaled end of count: continuous reload first, then a single pass that stops
      wr16(OFS_DR_L, 16'h0002);
      wr(OFS_IER, 8'h01);
      wr(OFS_CTL, 8'h07);
      repeat (20) @(posedge clk);
      rd(OFS_IIR, 8'h01);
      wr(OFS_CTL, 8'h03);
      repeat (20) @(posedge clk);
      `CHK(irq, 1'b1)
      rd(OFS_IIR, 8'h01);
      rd(OFS_CTL, 8'h00);
      rd16(OFS_DR_L, 16'h0000);
      conclude();
   end
endmodule : tb_timer_capture_compare_modes
